// ===== scdd_pkg.sv
// Summary of operation
// R1 - Receive buffer 16k words, transmit 8k words.
// R2 - Transmit buffer write-only, receive buffer read-only.
// R3 - Buffer test copies transmit writes into receive.
// R4 - Interrupt on transmit almost-empty, receive almost-full.
// R5 - Per-condition masks plus master channel enable.
// R6 - Raw status always readable for polling.
// R7 - Pointer write starts twelve-byte descriptor read.
// R8 - Descriptor: address, byte length, next pointer.
// R9 - Bit0 marks last, bit1 gives direction.
// R10 - Software sets direction bit in every pointer.
// R11 - Clear flag bits, follow chain until last.
// R12 - Inbound fills transmit, outbound drains receive.
// R13 - Test bit feeds receiver from transmitter.
// R14 - Channels 0-3 half duplex; 4,5 full.
// R15 - Data-only mode drops control, packs bytes LSB-first.
// R16 - Receiver disable flushes partial word zero-filled.
// R17 - Store-all keeps ten bits per character.
// R18 - Three characters per word, top bits zero.
// R19 - Compact mode drops repeated control characters.
// R20 - Transmitter sends least significant byte first.
// R21 - Receiver stores while enabled and space remains.
// R22 - DMA pauses on full or empty buffer.
package scdd_pkg;

	localparam int TX_DEPTH = 8192;
	localparam int RX_DEPTH = 16384;
	localparam int DESC_WORDS = 3;
	localparam logic [31:0] BYTES_PER_WORD = 32'h0000_0004;
	localparam int FLAG_LAST = 0;
	localparam int FLAG_DIR = 1;
	localparam logic [31:0] FLAG_CLEAR = 32'hffff_fffc;
	localparam int CHAR_CTRL = 8;
	localparam int CHAR_VIOL = 9;

	typedef enum logic [1:0] {
		MODE_DATA = 2'h0,
		MODE_ALL  = 2'h1,
		MODE_CMPT = 2'h2
	} scdd_mode_t;

	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_REQ  = 3'h1,
		DS_WAIT = 3'h3,
		DS_DATA = 3'h2,
		DS_NEXT = 3'h6
	} scdd_dma_state_t;

	localparam int IRQ_TX_AE = 0;
	localparam int IRQ_RX_AF = 1;
	localparam int IRQ_DONE = 2;
	localparam int IRQ_VIOL = 3;
	localparam int IRQ_RX_OVF = 4;
	localparam int IRQ_N = 5;

endpackage

// ===== scdd_fifo.sv
`timescale 1ns/10ps
// Synchronous first-in first-out store with occupancy count.
module scdd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8192,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             CLK,     // System clock.
	input  wire logic             RST,     // Synchronous reset.
	input  wire logic             WR,      // Write strobe.
	input  wire logic [WIDTH-1:0] WDATA,   // Write data.
	input  wire logic             RD,      // Read strobe.
	output logic      [WIDTH-1:0] RDATA,   // Head word.
	output logic                  FULL,    // No space left.
	output logic                  EMPTY,   // Nothing stored.
	output logic      [AW:0]      COUNT    // Words stored.
);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} scdd_fifo_st_t;

	logic [WIDTH-1:0] mem [DEPTH];
	scdd_fifo_st_t    st;
	scdd_fifo_st_t    next_st;
	logic             do_wr;
	logic             do_rd;

	// Status and qualified strobes.
	assign FULL  = (st.cnt == (AW+1)'(DEPTH));
	assign EMPTY = (st.cnt == '0);
	assign COUNT = st.cnt;
	assign RDATA = mem[st.rp];
	assign do_wr = WR && !FULL;
	assign do_rd = RD && !EMPTY;

	// Pointer and count update.
	always_comb begin
		next_st = st;
		if (do_wr) begin
			next_st.wp = st.wp + 1'b1;
		end
		if (do_rd) begin
			next_st.rp = st.rp + 1'b1;
		end
		next_st.cnt = st.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	end

	// Storage write.
	always_ff @(posedge CLK) begin
		if (do_wr) begin
			mem[st.wp] <= WDATA;
		end
	end

	// State register.
	always_ff @(posedge CLK) begin
		if (RST) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

// ===== scdd_chan.sv
`timescale 1ns/10ps
// One serial channel: DMA engine, transmit and receive buffers, packer.
module scdd_chan #(
	parameter int        TX_DEPTH = scdd_pkg::TX_DEPTH,
	parameter int        RX_DEPTH = scdd_pkg::RX_DEPTH,
	parameter bit        HALF_DUPLEX = 1'b1,
	parameter int        TXAW = $clog2(TX_DEPTH),
	parameter int        RXAW = $clog2(RX_DEPTH)
) (
	input  wire logic        CLK,            // 100 MHz clock.
	input  wire logic        RST,            // Synchronous reset, high.
	// Configuration and status.
	input  wire logic        FIFO_TEST,      // Route transmit writes to receive.
	input  wire logic        LINK_TEST,      // Receiver fed from internal path.
	input  wire logic        RX_EN,          // Receiver enable.
	input  wire logic        TX_EN,          // Transmitter enable.
	input  wire logic        DRIVE_TX,       // Half-duplex: connector driven by TX.
	input  wire logic [1:0]  RX_MODE,        // Receive storage mode.
	input  wire logic [RXAW:0] RX_AF_LVL,    // Receive almost-full level.
	input  wire logic [TXAW:0] TX_AE_LVL,    // Transmit almost-empty level.
	input  wire logic [4:0]  IRQ_MASK,       // Per-condition enables.
	input  wire logic        IRQ_MASTER,     // Channel master enable.
	output logic      [4:0]  STATUS,         // Raw live conditions.
	output logic      [TXAW:0] TX_COUNT,     // Transmit buffer words.
	output logic      [RXAW:0] RX_COUNT,     // Receive buffer words.
	output logic             IRQ,            // Channel interrupt.
	// Single-word buffer access.
	input  wire logic        SW_WR,          // Write to transmit buffer.
	input  wire logic [31:0] SW_WDATA,       // Write word.
	input  wire logic        SW_RD,          // Pop from receive buffer.
	output logic      [31:0] SW_RDATA,       // Receive buffer head.
	// DMA start.
	input  wire logic        PTR_WR,         // Descriptor pointer written.
	input  wire logic [31:0] PTR_DATA,       // Pointer with flags.
	output logic             DMA_BUSY,       // Chain in progress.
	// Bus master port.
	output logic             M_REQ,          // Word access request.
	output logic             M_WE,           // 1 = write to host.
	output logic      [31:0] M_ADDR,         // Byte address.
	output logic      [31:0] M_WDATA,        // Word to host.
	input  wire logic        M_ACK,          // Access done.
	input  wire logic [31:0] M_RDATA,        // Word from host.
	// Transceiver side.
	output logic      [7:0]  TXD,            // Transmit byte.
	output logic             TX_STB,         // Byte valid.
	input  wire logic        TX_RDY,         // Transmitter takes byte.
	input  wire logic [9:0]  RXD_EXT,        // External receive char.
	input  wire logic        RXV_EXT,        // External char valid.
	input  wire logic [9:0]  RXD_INT,        // Internal test char.
	input  wire logic        RXV_INT,        // Internal char valid.
	output logic             SEL_TX_OUT      // Connector mux: 1 = transmitter.
);

	typedef struct packed {
		scdd_pkg::scdd_dma_state_t ds;
		logic        dir;       // 1 = board to host.
		logic        last;
		logic [1:0]  didx;      // Descriptor word index.
		logic [31:0] dptr;
		logic [31:0] baddr;
		logic [31:0] blen;
		logic [31:0] nptr;
		logic [31:0] mwdata;
		logic        done_ev;
		logic [1:0]  txb;       // Byte index within word.
		logic [7:0]  txd;
		logic        txs;
		logic [29:0] acc;
		logic [1:0]  fill;
		logic [9:0]  prev;
		logic        prev_v;
		logic        rx_en_d;
		logic        viol_ev;
	} scdd_ch_st_t;

	scdd_ch_st_t st;
	scdd_ch_st_t next_st;

	logic        txf_wr, txf_rd, txf_full, txf_empty;
	logic [31:0] txf_wdata, txf_rdata;
	logic        rxf_wr, rxf_rd, rxf_full, rxf_empty;
	logic [31:0] rxf_wdata, rxf_rdata;
	logic [TXAW:0] txf_cnt;
	logic [RXAW:0] rxf_cnt;
	logic        dma_wr_tx, dma_rd_rx, pack_wr;
	logic [31:0] pack_word;
	logic [9:0]  rx_char;
	logic        rx_valid;
	logic        rx_keep;
	logic        pos_last;
	logic        in_room;

	// ********************************
	// Buffers.
	// ********************************

	// R1 transmit buffer, 8k words.
	scdd_fifo #(.WIDTH(32), .DEPTH(TX_DEPTH)) u_txf (
		.CLK   (CLK),
		.RST   (RST),
		.WR    (txf_wr),
		.WDATA (txf_wdata),
		.RD    (txf_rd),
		.RDATA (txf_rdata),
		.FULL  (txf_full),
		.EMPTY (txf_empty),
		.COUNT (txf_cnt)
	);

	// R1 receive buffer, 16k words.
	scdd_fifo #(.WIDTH(32), .DEPTH(RX_DEPTH)) u_rxf (
		.CLK   (CLK),
		.RST   (RST),
		.WR    (rxf_wr),
		.WDATA (rxf_wdata),
		.RD    (rxf_rd),
		.RDATA (rxf_rdata),
		.FULL  (rxf_full),
		.EMPTY (rxf_empty),
		.COUNT (rxf_cnt)
	);

	// ********************************
	// Buffer routing.
	// ********************************

	// R22 inbound room is checked in the buffer that really takes the word.
	// In buffer test mode that is the receive buffer, so no word is dropped there.
	assign in_room   = FIFO_TEST ? !rxf_full : !txf_full;
	// R2 write-only transmit path, inbound DMA or single word.
	assign dma_wr_tx = (st.ds == scdd_pkg::DS_DATA) && !st.dir && M_ACK && in_room;
	// Only a word that stands at the head is popped, so a late answer never repeats one.
	assign dma_rd_rx = (st.ds == scdd_pkg::DS_DATA) && st.dir && M_ACK && !rxf_empty;
	assign txf_wdata = dma_wr_tx ? M_RDATA : SW_WDATA;
	// R3 buffer test diverts written words to receive.
	assign txf_wr    = (dma_wr_tx || SW_WR) && !FIFO_TEST;
	// R2 read-only receive path.
	assign rxf_rd    = SW_RD || dma_rd_rx;
	assign SW_RDATA  = rxf_rdata;
	// R3 full-width copy in test mode, else packer output.
	assign rxf_wr    = FIFO_TEST ? (dma_wr_tx || SW_WR) : pack_wr;
	assign rxf_wdata = FIFO_TEST ? txf_wdata : pack_word;
	assign TX_COUNT  = txf_cnt;
	assign RX_COUNT  = rxf_cnt;

	// ********************************
	// Receive path.
	// ********************************

	// R13 receiver source selection.
	assign rx_char  = LINK_TEST ? RXD_INT : RXD_EXT;
	assign rx_valid = (LINK_TEST ? RXV_INT : RXV_EXT) && RX_EN;
	// R14 half-duplex mux, fixed for full-duplex channels.
	assign SEL_TX_OUT = HALF_DUPLEX ? DRIVE_TX : 1'b1;

	// R15 data-only drops control; R19 compact drops repeated control chars.
	always_comb begin
		rx_keep = 1'b1;
		if (RX_MODE == scdd_pkg::MODE_DATA) begin
			rx_keep = !rx_char[scdd_pkg::CHAR_CTRL];
		end else if (RX_MODE == scdd_pkg::MODE_CMPT) begin
			rx_keep = !rx_char[scdd_pkg::CHAR_CTRL] || !st.prev_v || (rx_char != st.prev);
		end
	end
	// Word is complete after 4 bytes or 3 ten-bit chars.
	assign pos_last = (RX_MODE == scdd_pkg::MODE_DATA) ? (st.fill == 2'h3) : (st.fill == 2'h2);

	// Packing of received characters into words.
	always_comb begin
		pack_wr   = 1'b0;
		pack_word = '0;
		// R21 store while enabled and room remains.
		if (rx_valid && rx_keep && pos_last && !rxf_full) begin
			pack_wr = 1'b1;
			if (RX_MODE == scdd_pkg::MODE_DATA) begin
				// R15 fourth byte into top lane.
				pack_word = {rx_char[7:0], st.acc[23:0]};
			end else begin
				// R18 third char in 29-20, bits 31-30 zero.
				pack_word = {2'h0, rx_char, st.acc[19:0]};
			end
		// R16 flush partial word on receiver disable.
		end else if (st.rx_en_d && !RX_EN && st.fill != 2'h0 && !rxf_full) begin
			pack_wr   = 1'b1;
			pack_word = {2'h0, st.acc};
		end
	end

	// ********************************
	// Transmit and DMA control.
	// ********************************

	// A transmit word is released once its top byte has been taken.
	assign txf_rd = st.txb == 2'h3 && TX_STB && TX_RDY;

	// Channel next-state logic.
	always_comb begin
		next_st         = st;
		next_st.done_ev = 1'b0;
		next_st.viol_ev = 1'b0;
		next_st.rx_en_d = RX_EN;
		M_REQ   = 1'b0;
		M_WE    = 1'b0;
		M_ADDR  = st.dptr;
		case (st.ds)
			scdd_pkg::DS_IDLE: begin
				// R7 pointer write starts descriptor fetch.
				if (PTR_WR) begin
					// R10 direction taken from the pointer flags.
					next_st.dir  = PTR_DATA[scdd_pkg::FLAG_DIR];
					next_st.dptr = PTR_DATA & scdd_pkg::FLAG_CLEAR;
					next_st.didx = 2'h0;
					next_st.ds   = scdd_pkg::DS_REQ;
				end
			end
			scdd_pkg::DS_REQ: begin
				// R8 three descriptor words at consecutive addresses.
				// The request and its address stand until the host answers.
				M_REQ  = 1'b1;
				M_ADDR = st.dptr + {28'h0, st.didx, 2'h0};
				if (M_ACK) begin
					if (st.didx == 2'h0) begin
						next_st.baddr = M_RDATA;
					end else if (st.didx == 2'h1) begin
						next_st.blen = M_RDATA;
					end else begin
						// R9 last and direction flags.
						next_st.nptr = M_RDATA & scdd_pkg::FLAG_CLEAR;
						next_st.last = M_RDATA[scdd_pkg::FLAG_LAST];
						next_st.dir  = M_RDATA[scdd_pkg::FLAG_DIR];
					end
					next_st.didx = st.didx + 2'h1;
					if (st.didx == 2'(scdd_pkg::DESC_WORDS - 1)) begin
						next_st.ds = scdd_pkg::DS_WAIT;
					end
				end
			end
			scdd_pkg::DS_WAIT: begin
				// Block of zero length is skipped.
				next_st.ds = (st.blen == '0) ? scdd_pkg::DS_NEXT : scdd_pkg::DS_DATA;
			end
			scdd_pkg::DS_DATA: begin
				// R12 inbound fills transmit, outbound drains receive.
				M_ADDR = st.baddr;
				M_WE   = st.dir;
				// R22 stall while buffer full or empty.
				// Dropping the request while stalled restarts the host wait count.
				M_REQ  = st.dir ? !rxf_empty : in_room;
				if (M_ACK && M_REQ) begin
					next_st.baddr = st.baddr + scdd_pkg::BYTES_PER_WORD;
					if (st.blen <= scdd_pkg::BYTES_PER_WORD) begin
						next_st.blen = '0;
						next_st.ds   = scdd_pkg::DS_NEXT;
					end else begin
						next_st.blen = st.blen - scdd_pkg::BYTES_PER_WORD;
					end
				end
			end
			scdd_pkg::DS_NEXT: begin
				// R11 follow chain until last descriptor.
				if (st.last) begin
					next_st.ds      = scdd_pkg::DS_IDLE;
					next_st.done_ev = 1'b1;
				end else begin
					next_st.dptr = st.nptr;
					next_st.didx = 2'h0;
					next_st.ds   = scdd_pkg::DS_REQ;
				end
			end
			default: begin
				next_st.ds = scdd_pkg::DS_IDLE;
			end
		endcase

		// R20 least significant byte first.
		if (!st.txs && TX_EN && !txf_empty) begin
			next_st.txs = 1'b1;
			next_st.txd = txf_rdata[8*st.txb +: 8];
		end else if (st.txs && TX_RDY) begin
			next_st.txb = st.txb + 2'h1;
			next_st.txs = 1'b0;
		end

		// Receive accumulation.
		if (rx_valid) begin
			next_st.prev   = rx_char;
			next_st.prev_v = 1'b1;
			next_st.viol_ev = rx_char[scdd_pkg::CHAR_VIOL];
		end
		if (pack_wr && !(st.rx_en_d && !RX_EN)) begin
			next_st.fill = 2'h0;
			next_st.acc  = '0;
		end else if (pack_wr) begin
			// R16 partial word written, restart empty.
			next_st.fill = 2'h0;
			next_st.acc  = '0;
		end else if (rx_valid && rx_keep && !rxf_full) begin
			next_st.fill = st.fill + 2'h1;
			if (RX_MODE == scdd_pkg::MODE_DATA) begin
				next_st.acc[8*st.fill +: 8] = rx_char[7:0];
			end else begin
				// R17 ten-bit items with control and violation flags.
				next_st.acc[10*st.fill +: 10] = rx_char;
			end
		end
	end

	// Bus write data and transmit outputs come straight from state or buffer head.
	assign M_WDATA  = rxf_rdata;
	assign DMA_BUSY = st.ds != scdd_pkg::DS_IDLE;
	assign TXD      = st.txd;
	assign TX_STB   = st.txs;

	// ********************************
	// Status and interrupt.
	// ********************************

	// R4 R6 live conditions, readable unmasked.
	assign STATUS[scdd_pkg::IRQ_TX_AE]  = txf_cnt <= TX_AE_LVL;
	assign STATUS[scdd_pkg::IRQ_RX_AF]  = rxf_cnt >= RX_AF_LVL;
	assign STATUS[scdd_pkg::IRQ_DONE]   = st.done_ev;
	assign STATUS[scdd_pkg::IRQ_VIOL]   = st.viol_ev;
	assign STATUS[scdd_pkg::IRQ_RX_OVF] = rx_valid && rx_keep && rxf_full;
	// R5 per-condition masks and master enable.
	assign IRQ = IRQ_MASTER && |(STATUS & IRQ_MASK);

	// ********************************
	// State register.
	// ********************************

	// All channel state is taken at the clock edge.
	always_ff @(posedge CLK) begin
		if (RST) begin
			st    <= '0;
			st.ds <= scdd_pkg::DS_IDLE;
		end else begin
			st <= next_st;
		end
	end

endmodule

// ===== scdd_chan_checker.sv
`timescale 1ns/10ps
// ********************************
// Port checker for one channel.
// ********************************
module scdd_chan_checker #(
	parameter int TXAW        = 4,
	parameter int RXAW        = 5,
	parameter bit HALF_DUPLEX = 1'b1
) (
	input wire logic            CLK,        // Clock.
	input wire logic            RST,        // Reset.
	input wire logic            DRIVE_TX,   // Mux request.
	input wire logic [RXAW:0]   RX_AF_LVL,  // Receive level.
	input wire logic [TXAW:0]   TX_AE_LVL,  // Transmit level.
	input wire logic [4:0]      IRQ_MASK,   // Masks.
	input wire logic            IRQ_MASTER, // Master enable.
	input wire logic [4:0]      STATUS,     // Raw status.
	input wire logic [TXAW:0]   TX_COUNT,   // Transmit words.
	input wire logic [RXAW:0]   RX_COUNT,   // Receive words.
	input wire logic            IRQ,        // Interrupt.
	input wire logic            PTR_WR,     // Start strobe.
	input wire logic [31:0]     PTR_DATA,   // Start pointer.
	input wire logic            DMA_BUSY,   // Chain busy.
	input wire logic            M_REQ,      // Bus request.
	input wire logic            M_WE,       // Bus direction.
	input wire logic [31:0]     M_ADDR,     // Bus address.
	input wire logic            M_ACK,      // Bus answer.
	input wire logic [7:0]      TXD,        // Transmit byte.
	input wire logic            TX_STB,     // Byte valid.
	input wire logic            TX_RDY,     // Byte taken.
	input wire logic            SEL_TX_OUT  // Mux select.
);
	logic [1:0]  dcnt;
	logic [31:0] dbase;

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// Counts descriptor words fetched since the last accepted start.
	always_ff @(posedge CLK) begin
		if (RST) begin
			dcnt <= 2'h3;
		end else if (PTR_WR && !DMA_BUSY) begin
			dcnt <= 2'h0;
			dbase <= PTR_DATA & scdd_pkg::FLAG_CLEAR;
		end else if (M_REQ && M_ACK && dcnt != 2'h3) begin
			dcnt <= dcnt + 2'h1;
		end
	end

	sequence s_go;
		PTR_WR && !DMA_BUSY;
	endsequence
	sequence s_byte_wait;
		TX_STB && !TX_RDY;
	endsequence

	a_irq_mask_gate: assert property (
		IRQ == (IRQ_MASTER && |(STATUS & IRQ_MASK))) else $error("interrupt not gated by masks");
	a_tx_low_level: assert property (
		STATUS[0] == (TX_COUNT <= TX_AE_LVL)) else $error("transmit level flag wrong");
	a_rx_high_level: assert property (
		STATUS[1] == (RX_COUNT >= RX_AF_LVL)) else $error("receive level flag wrong");
	a_start_fetch: assert property (
		s_go |=> M_REQ && !M_WE && M_ADDR == ($past(PTR_DATA) & scdd_pkg::FLAG_CLEAR))
		else $error("first descriptor read missing");
	a_desc_order: assert property (
		M_REQ && DMA_BUSY && dcnt != 2'h3 |-> !M_WE && M_ADDR == dbase + {28'h0, dcnt, 2'h0})
		else $error("descriptor word address wrong");
	a_req_holds: assert property (
		(M_REQ && !M_ACK) ##1 M_REQ |-> $stable(M_ADDR) && $stable(M_WE))
		else $error("bus request changed before answer");
	a_byte_holds: assert property (
		s_byte_wait |=> TX_STB && $stable(TXD)) else $error("transmit byte dropped");
	a_duplex_sel: assert property (
		$stable(DRIVE_TX) && !$past(RST) |-> SEL_TX_OUT == (DRIVE_TX || !HALF_DUPLEX))
		else $error("connector select wrong");
	a_done_pulse: assert property (
		STATUS[2] |=> !STATUS[2]) else $error("done flag longer than one cycle");
endmodule

// ===== scdd_host_mem.sv
`timescale 1ns/10ps
// ********************************
// Host memory reached by bus master.
// ********************************
module scdd_host_mem (
	input  wire logic        clk,    // Clock.
	input  wire logic        rst,    // Reset.
	input  wire logic [1:0]  slow,   // Wait cycles per access.
	input  wire logic        m_req,  // Request.
	input  wire logic        m_we,   // Write to host.
	input  wire logic [31:0] m_addr, // Byte address.
	input  wire logic [31:0] m_wd,   // Write word.
	output logic             m_ack,  // One-cycle answer.
	output logic      [31:0] m_rd    // Read word.
);
	logic [31:0] mem [0:255];
	logic [31:0] rd;
	logic [1:0]  w;

	// Outside an answer the read bus shows the inverse, never stale data.
	assign m_rd = m_ack ? rd : ~rd;

	// Answers after the set wait and commits a write on the same edge.
	always @(posedge clk) begin
		if (rst) begin
			m_ack <= 1'h0;
			w <= 2'h0;
		end else if (m_ack || !m_req) begin
			m_ack <= 1'h0;
			w <= 2'h0;
		end else if (w >= slow) begin
			m_ack <= 1'h1;
			rd <= mem[m_addr[9:2]];
			if (m_we) mem[m_addr[9:2]] <= m_wd;
		end else begin
			w <= w + 2'h1;
		end
	end
endmodule

// ===== tb_serial_channel_dma_datapath.sv
`timescale 1ns/10ps
// ********************************
// Bench for one serial channel.
// ********************************
module tb_serial_channel_dma_datapath;
	logic clk = 1'h0, rst = 1'h1, fifo_test = 1'h0, link_test = 1'h0, rx_en = 1'h0;
	logic tx_en = 1'h0, drive_tx = 1'h0, irq_master = 1'h0, sw_wr = 1'h0, sw_rd = 1'h0;
	logic ptr_wr = 1'h0, tx_rdy = 1'h0, rxv_e = 1'h0, rxv_i = 1'h0;
	logic irq, busy, m_req, m_we, m_ack, txs, sel;
	logic [1:0] rx_mode = 2'h0, slow = 2'h0;
	logic [5:0] rx_af = 6'h02, rx_cnt;
	logic [4:0] tx_ae = 5'h02, irq_mask = 5'h00, status, tx_cnt;
	logic [31:0] sw_wd = 32'h0, ptr = 32'h0, sw_rdat, m_addr, m_wd, m_rd;
	logic [9:0] rxd_e = 10'h0, rxd_i = 10'h0;
	logic [7:0] txd;
	logic [7:0] bq [$];
	int err_total = 0, compares = 0;

	always #5 clk = ~clk;

	scdd_chan #(.TX_DEPTH(16), .RX_DEPTH(32), .HALF_DUPLEX(1'b1)) i_dut (
		.CLK(clk), .RST(rst), .FIFO_TEST(fifo_test), .LINK_TEST(link_test), .RX_EN(rx_en),
		.TX_EN(tx_en), .DRIVE_TX(drive_tx), .RX_MODE(rx_mode), .RX_AF_LVL(rx_af),
		.TX_AE_LVL(tx_ae), .IRQ_MASK(irq_mask), .IRQ_MASTER(irq_master), .STATUS(status),
		.TX_COUNT(tx_cnt), .RX_COUNT(rx_cnt), .IRQ(irq), .SW_WR(sw_wr), .SW_WDATA(sw_wd),
		.SW_RD(sw_rd), .SW_RDATA(sw_rdat), .PTR_WR(ptr_wr), .PTR_DATA(ptr), .DMA_BUSY(busy),
		.M_REQ(m_req), .M_WE(m_we), .M_ADDR(m_addr), .M_WDATA(m_wd), .M_ACK(m_ack),
		.M_RDATA(m_rd), .TXD(txd), .TX_STB(txs), .TX_RDY(tx_rdy), .RXD_EXT(rxd_e),
		.RXV_EXT(rxv_e), .RXD_INT(rxd_i), .RXV_INT(rxv_i), .SEL_TX_OUT(sel));

	scdd_host_mem i_mem (.*);

	// Collects every byte the transmitter hands over.
	always @(posedge clk) if (txs && tx_rdy) bq.push_back(txd);

	// ********************************
	// Access tasks.
	// ********************************
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task report_and_stop;
		$display("Mismatches %0d, compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task swr(input logic [31:0] d);
		@(negedge clk) {sw_wr, sw_wd} = {1'h1, d};
		@(negedge clk) sw_wr = 1'h0;
	endtask
	task srd(input logic [31:0] e);
		repeat (3) @(negedge clk);
		chk("rx word", sw_rdat, e);
		sw_rd = 1'h1;
		@(negedge clk) sw_rd = 1'h0;
	endtask
	// Sends a char on the chosen path and its inverse on the other one.
	task rxc(input logic [9:0] c, input logic in);
		@(negedge clk) {rxd_e, rxd_i, rxv_e, rxv_i} = {in ? ~c : c, in ? c : ~c, 2'h3};
		@(negedge clk) {rxv_e, rxv_i} = 2'h0;
	endtask
	task dma(input logic [31:0] p);
		@(negedge clk) {ptr_wr, ptr} = {1'h1, p};
		@(negedge clk) ptr_wr = 1'h0;
	endtask
	task idle;
		for (int i = 0; i < 400 && busy !== 1'h0; i++) @(negedge clk);
		chk("busy", busy, 32'h0);
	endtask

	// Cuts a hang short; the tests need well under half this span.
	initial begin
		repeat (6000) @(posedge clk);
		err_total++;
		report_and_stop;
	end

	// ********************************
	// Test sequence.
	// ********************************
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk) {rst, irq_mask, irq_master} = {1'h0, 5'h01, 1'h1};
		@(negedge clk) chk("irq on", irq, 32'h1);
		irq_master = 1'h0;
		@(negedge clk) chk("irq off", irq, 32'h0);
		chk("low flag", status[0], 32'h1);
		for (int i = 0; i < 17; i++) swr(32'h03020100 + i * 32'h04040404);
		chk("tx full", tx_cnt, 32'h10);
		chk("low flag", status[0], 32'h0);
		chk("rx empty", rx_cnt, 32'h0);
		tx_en = 1'h1;
		repeat (3) @(negedge clk);
		tx_rdy = 1'h1;
		for (int i = 0; i < 600 && bq.size() < 64; i++) @(negedge clk);
		for (int i = 0; i < 64; i++) chk("tx byte", bq[i], 32'(i));
		{tx_en, drive_tx} = 2'h1;
		repeat (2) @(negedge clk) chk("mux", sel, 32'h1);
		drive_tx = 1'h0;
		repeat (2) @(negedge clk) chk("mux", sel, 32'h0);
		fifo_test = 1'h1;
		swr(32'hcafe0001);
		swr(32'h5a5aa5a5);
		@(negedge clk) chk("rx count", rx_cnt, 32'h2);
		chk("tx count", tx_cnt, 32'h0);
		chk("high flag", status[1], 32'h1);
		srd(32'hcafe0001);
		srd(32'h5a5aa5a5);
		{fifo_test, rx_en} = 2'h1;
		rxc(10'h1bc, 1'h0);
		rxc(10'h0a1, 1'h0);
		rxc(10'h0b2, 1'h0);
		rxc(10'h0c3, 1'h0);
		rxc(10'h0d4, 1'h0);
		rxc(10'h0e5, 1'h0);
		rx_en = 1'h0;
		srd(32'hd4c3b2a1);
		srd(32'h000000e5);
		{rx_mode, link_test, rx_en} = 4'h7;
		rxc(10'h1bc, 1'h1);
		rxc(10'h011, 1'h1);
		rxc(10'h2ff, 1'h1);
		chk("viol", status[3], 32'h1);
		srd({2'h0, 10'h2ff, 10'h011, 10'h1bc});
		{rx_mode, link_test} = 3'h4;
		rxc(10'h17c, 1'h0);
		rxc(10'h17c, 1'h0);
		rxc(10'h005, 1'h0);
		rxc(10'h17c, 1'h0);
		srd({2'h0, 10'h17c, 10'h005, 10'h17c});
		{fifo_test, rx_en} = 2'h2;
		{i_mem.mem[16], i_mem.mem[17], i_mem.mem[18]} = {32'h100, 32'h8, 32'h50};
		{i_mem.mem[20], i_mem.mem[21], i_mem.mem[22]} = {32'h108, 32'h6, 32'h1};
		{i_mem.mem[24], i_mem.mem[25], i_mem.mem[26]} = {32'h180, 32'h14, 32'h3};
		for (int i = 0; i < 4; i++) i_mem.mem[64 + i] = 32'h11110000 + i;
		dma(32'h40);
		idle;
		chk("done", status[2], 32'h1);
		chk("rx after in", rx_cnt, 32'h4);
		slow = 2'h2;
		dma(32'h62);
		repeat (100) @(negedge clk);
		chk("stalled", busy, 32'h1);
		dma(32'h40);
		swr(32'h77);
		idle;
		for (int i = 0; i < 5; i++) chk("host", i_mem.mem[96 + i], i < 4 ? 32'h11110000 + i : 32'h77);
		chk("rx drained", rx_cnt, 32'h0);
		report_and_stop;
	end
endmodule

bind scdd_chan scdd_chan_checker #(.TXAW(TXAW), .RXAW(RXAW), .HALF_DUPLEX(HALF_DUPLEX)) i_chk (.*);
